/* File: core/irq_prio_enc.sv */
// Purpose: Shared constants of the interrupt prioritizer, and its fixed-priority encoder.
// Assumes: Index 0 carries the highest priority; vectors are two bytes apart from address zero.
// Notes:   The encoder is purely combinational; the caller registers its result.
`timescale 1ns/1ps
`default_nettype none
package irq_pkg;
    // Source count, widths and vector spacing
    localparam int          NUM_SRC      = 16;
    localparam int          IDX_W        = 4;
    localparam int          VEC_W        = 16;
    localparam logic [15:0] VEC_BASE     = 16'h0000;
    localparam logic [15:0] VEC_STEP     = 16'h0002;

    // Source positions, in vector table order
    localparam int SRC_RESET       = 0;
    localparam int SRC_NMI         = 1;
    localparam int SRC_SPARE       = 2;
    localparam int SRC_EXT_TWO     = 3;
    localparam int SRC_LOW_STROBE  = 4;
    localparam int SRC_TIMER_A_OUT = 5;
    localparam int SRC_TIMER_A_PIN = 6;
    localparam int SRC_HIGH_STROBE = 7;
    localparam int SRC_RX_SPECIAL  = 8;
    localparam int SRC_RX_NORMAL   = 9;
    localparam int SRC_EXT_ONE     = 10;
    localparam int SRC_TIMER_B_OUT = 11;
    localparam int SRC_TIMER_B_IN  = 12;
    localparam int SRC_EXT_ZERO    = 13;
    localparam int SRC_TRANSMIT    = 14;
    localparam int SRC_TIMER_C     = 15;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFS_LATCH    = 8'h00;
    localparam logic [7:0] OFS_IENABLE  = 8'h04;
    localparam logic [7:0] OFS_PSTATUS  = 8'h08;
    localparam logic [7:0] OFS_TCTRL    = 8'h0C;
    localparam logic [7:0] OFS_WAKE     = 8'h10;
    localparam logic [7:0] OFS_LASTVEC  = 8'h14;
    localparam logic [7:0] OFS_EVSTAT   = 8'h18;
    localparam logic [7:0] OFS_EVCLEAR  = 8'h1C;
    localparam logic [7:0] OFS_EVENABLE = 8'h20;

    // Field positions
    localparam int PS_GIE_BIT     = 0;
    localparam int TC_EDGE_LSB    = 0;
    localparam int TC_EDGE_W      = 4;
    localparam int TC_TIMER_LSB   = 8;
    localparam int TC_TIMER_W     = 8;
    localparam int WK_EN_BIT      = 0;
    localparam int WK_MATCH_BIT   = 1;
    localparam int WK_ADDR_LSB    = 8;
    localparam int WK_ADDR_W      = 8;

    // Sticky event bits
    localparam int EV_ACK     = 0;
    localparam int EV_NMI     = 1;
    localparam int EV_WAKE    = 2;
    localparam int EV_BADADR  = 3;
    localparam int EV_W       = 4;

    // Reset values
    localparam logic [15:0] RST_LATCH   = 16'h0001;
    localparam logic [15:0] RST_IENABLE = 16'h0000;
    localparam logic [15:0] RST_TCTRL   = 16'h0000;
    localparam logic [15:0] RST_WAKE    = 16'h0000;
endpackage

// Lowest set index wins
module irq_prio_enc #(
    parameter int N = irq_pkg::NUM_SRC,
    parameter int W = irq_pkg::IDX_W
) (
    input  wire logic [N-1:0] req,
    output logic              any,
    output logic [W-1:0]      idx
);
    // Scan downward so the final assignment is the lowest pending index
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule

`default_nettype wire

/* File: core/vectored_interrupt_prioritizer.sv */
// Purpose: Sixteen-source vectored interrupt controller with Avalon-MM register access.
// Assumes: All source inputs are synchronous to clk_sys; event inputs are one-cycle pulses.
// Notes:   The core sees a level request and a vector; one ack pulse takes the shown vector.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_prioritizer (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt sources
    input  wire logic        nmi_pin,
    input  wire logic        ext_irq_zero,
    input  wire logic        ext_irq_one,
    input  wire logic        ext_irq_two,
    input  wire logic        low_strobe_irq,
    input  wire logic        high_strobe_irq,
    input  wire logic        timer_a_output_irq,
    input  wire logic        timer_a_input_pin,
    input  wire logic        timer_b_output_irq,
    input  wire logic        timer_b_input_irq,
    input  wire logic        rx_special_condition_irq,
    input  wire logic        rx_word_valid,
    input  wire logic        rx_word_is_addr,
    input  wire logic [7:0]  rx_word_data,
    input  wire logic        transmit_irq,
    input  wire logic        timer_c_irq,
    // Core side
    input  wire logic        enable_interrupts_instr,
    input  wire logic        disable_interrupts_instr,
    input  wire logic        core_irq_ack,
    output logic             core_irq_req,
    output logic [15:0]      core_vector,
    output logic             core_gie,
    output logic             timer_a_level,
    output logic [7:0]       timer_ctrl,
    output logic             irq
);

    localparam int N = irq_pkg::NUM_SRC;
    localparam int W = irq_pkg::IDX_W;

    // Register state
    logic [N-1:0]             latch_q;
    logic [N-1:0]             latch_d;
    logic [N-1:0]             ienable_q;
    logic                     gie_q;
    logic [15:0]              tctrl_q;
    logic [15:0]              wake_q;
    logic [15:0]              lastvec_q;
    logic [irq_pkg::EV_W-1:0] evstat_q;
    logic [irq_pkg::EV_W-1:0] evenable_q;
    logic [irq_pkg::EV_W-1:0] ev_set;
    logic                     irq_q;

    // Bus state
    logic                     wait_q;
    logic [31:0]              rdata_q;
    logic [31:0]              rdata_d;
    logic                     acc;
    logic                     wr_acc;
    logic                     rd_first;
    logic                     addr_ok;

    // Source conditioning
    logic                     nmi_prev_q;
    logic [2:0]               ext_prev_q;
    logic                     ta_pin_q;
    logic                     ta_pin_prev_q;
    logic [2:0]               ext_edge;
    logic                     ta_pin_edge;
    logic                     rx_normal_ev;
    logic [N-1:0]             src_ev;

    // Prioritization and presentation
    logic [N-1:0]             eligible;
    logic                     win_any;
    logic [W-1:0]             win_idx;
    logic                     req_q;
    logic [W-1:0]             show_idx_q;
    logic [15:0]              vec_q;
    logic                     ack_take;

    // Edge detection on pins; a set select bit means rising edge, clear means falling
    always_comb begin
        ext_edge[0] = tctrl_q[irq_pkg::TC_EDGE_LSB + 0] ? (ext_irq_zero & ~ext_prev_q[0])
                                                        : (~ext_irq_zero & ext_prev_q[0]);
        ext_edge[1] = tctrl_q[irq_pkg::TC_EDGE_LSB + 1] ? (ext_irq_one & ~ext_prev_q[1])
                                                        : (~ext_irq_one & ext_prev_q[1]);
        ext_edge[2] = tctrl_q[irq_pkg::TC_EDGE_LSB + 2] ? (ext_irq_two & ~ext_prev_q[2])
                                                        : (~ext_irq_two & ext_prev_q[2]);
        ta_pin_edge = tctrl_q[irq_pkg::TC_EDGE_LSB + 3] ? (ta_pin_q & ~ta_pin_prev_q)
                                                        : (~ta_pin_q & ta_pin_prev_q);
    end

    // Pin history; the timer A pin level is also handed on to the timer and port logic
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            nmi_prev_q    <= 1'b0;
            ext_prev_q    <= 3'h0;
            ta_pin_q      <= 1'b0;
            ta_pin_prev_q <= 1'b0;
        end else begin
            nmi_prev_q    <= nmi_pin;
            ext_prev_q    <= {ext_irq_two, ext_irq_one, ext_irq_zero};
            ta_pin_q      <= timer_a_input_pin;
            ta_pin_prev_q <= ta_pin_q;
        end
    end

    // Wake-up receive filter: data words raise nothing while wake mode is on
    always_comb begin
        rx_normal_ev = 1'b0;
        if (rx_word_valid) begin
            if (!wake_q[irq_pkg::WK_EN_BIT]) begin
                rx_normal_ev = 1'b1;
            end else if (rx_word_is_addr) begin
                rx_normal_ev = !wake_q[irq_pkg::WK_MATCH_BIT] ||
                    (rx_word_data == wake_q[irq_pkg::WK_ADDR_LSB +: irq_pkg::WK_ADDR_W]);
            end
        end
    end

    // One event line per table slot; the reset and spare slots have no source
    always_comb begin
        src_ev                           = '0;
        src_ev[irq_pkg::SRC_NMI]         = nmi_pin & ~nmi_prev_q;
        src_ev[irq_pkg::SRC_EXT_TWO]     = ext_edge[2];
        src_ev[irq_pkg::SRC_LOW_STROBE]  = low_strobe_irq;
        src_ev[irq_pkg::SRC_TIMER_A_OUT] = timer_a_output_irq;
        src_ev[irq_pkg::SRC_TIMER_A_PIN] = ta_pin_edge;
        src_ev[irq_pkg::SRC_HIGH_STROBE] = high_strobe_irq;
        src_ev[irq_pkg::SRC_RX_SPECIAL]  = rx_special_condition_irq;
        src_ev[irq_pkg::SRC_RX_NORMAL]   = rx_normal_ev;
        src_ev[irq_pkg::SRC_EXT_ONE]     = ext_edge[1];
        src_ev[irq_pkg::SRC_TIMER_B_OUT] = timer_b_output_irq;
        src_ev[irq_pkg::SRC_TIMER_B_IN]  = timer_b_input_irq;
        src_ev[irq_pkg::SRC_EXT_ZERO]    = ext_edge[0];
        src_ev[irq_pkg::SRC_TRANSMIT]    = transmit_irq;
        src_ev[irq_pkg::SRC_TIMER_C]     = timer_c_irq;
    end

    // Reset and the non-maskable slot bypass both enables; the rest need both
    always_comb begin
        eligible = latch_q & ienable_q & {N{gie_q}};
        eligible[irq_pkg::SRC_RESET] = latch_q[irq_pkg::SRC_RESET];
        eligible[irq_pkg::SRC_NMI]   = latch_q[irq_pkg::SRC_NMI];
    end

    irq_prio_enc #(
        .N (N),
        .W (W)
    ) u_enc (
        .req (eligible),
        .any (win_any),
        .idx (win_idx)
    );

    // An ack takes whatever vector the core was being shown
    assign ack_take = core_irq_ack & req_q;

    // Presented request and vector, registered so the core sees stable levels
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            req_q      <= 1'b0;
            show_idx_q <= '0;
            vec_q      <= irq_pkg::VEC_BASE;
        end else begin
            req_q      <= win_any & ~ack_take;
            show_idx_q <= win_idx;
            vec_q      <= irq_pkg::VEC_BASE + irq_pkg::VEC_STEP * 16'(win_idx);
        end
    end

    // Pending latches: a new event beats the ack or software clear in the same cycle
    always_comb begin
        latch_d = latch_q;
        if (ack_take) begin
            latch_d[show_idx_q] = 1'b0;
        end
        if (wr_acc && avs_address == irq_pkg::OFS_LATCH) begin
            latch_d = latch_d & ~avs_writedata[N-1:0];
        end
        latch_d = latch_d | src_ev;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            latch_q <= irq_pkg::RST_LATCH; // Reset vector pends first
        end else begin
            latch_q <= latch_d;
        end
    end

    // Global enable; hardware clear on ack outranks an enable in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            gie_q <= 1'b0;
        end else if (ack_take) begin
            gie_q <= 1'b0;
        end else if (disable_interrupts_instr) begin
            gie_q <= 1'b0;
        end else if (enable_interrupts_instr) begin
            gie_q <= 1'b1;
        end else if (wr_acc && avs_address == irq_pkg::OFS_PSTATUS) begin
            gie_q <= avs_writedata[irq_pkg::PS_GIE_BIT];
        end
    end

    // Software-written configuration
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ienable_q  <= irq_pkg::RST_IENABLE;
            tctrl_q    <= irq_pkg::RST_TCTRL;
            wake_q     <= irq_pkg::RST_WAKE;
            evenable_q <= '0;
        end else if (wr_acc) begin
            unique case (avs_address)
                irq_pkg::OFS_IENABLE:  ienable_q  <= avs_writedata[N-1:0];
                irq_pkg::OFS_TCTRL:    tctrl_q    <= avs_writedata[15:0];
                irq_pkg::OFS_WAKE:     wake_q     <= avs_writedata[15:0];
                irq_pkg::OFS_EVENABLE: evenable_q <= avs_writedata[irq_pkg::EV_W-1:0];
                default: ;
            endcase
        end
    end

    // Last acknowledged vector, for diagnostics
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lastvec_q <= irq_pkg::VEC_BASE;
        end else if (ack_take) begin
            lastvec_q <= vec_q;
        end
    end

    // Sticky events for the system-level interrupt line
    always_comb begin
        ev_set                     = '0;
        ev_set[irq_pkg::EV_ACK]    = ack_take;
        ev_set[irq_pkg::EV_NMI]    = src_ev[irq_pkg::SRC_NMI];
        ev_set[irq_pkg::EV_WAKE]   = rx_normal_ev & wake_q[irq_pkg::WK_EN_BIT];
        ev_set[irq_pkg::EV_BADADR] = acc & ~addr_ok;
    end

    // Clear register is write-one-to-clear; a same-cycle event keeps its bit set
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            evstat_q <= '0;
        end else if (wr_acc && avs_address == irq_pkg::OFS_EVCLEAR) begin
            evstat_q <= (evstat_q & ~avs_writedata[irq_pkg::EV_W-1:0]) | ev_set;
        end else begin
            evstat_q <= evstat_q | ev_set;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evstat_q & evenable_q);
        end
    end

    // Avalon decode; the clear register is write-only and reads zero
    always_comb begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        unique case (avs_address)
            irq_pkg::OFS_LATCH:    rdata_d[N-1:0]  = latch_q;
            irq_pkg::OFS_IENABLE:  rdata_d[N-1:0]  = ienable_q;
            irq_pkg::OFS_PSTATUS:  rdata_d[irq_pkg::PS_GIE_BIT] = gie_q;
            irq_pkg::OFS_TCTRL:    rdata_d[15:0]   = tctrl_q;
            irq_pkg::OFS_WAKE:     rdata_d[15:0]   = wake_q;
            irq_pkg::OFS_LASTVEC:  rdata_d[15:0]   = lastvec_q;
            irq_pkg::OFS_EVSTAT:   rdata_d[irq_pkg::EV_W-1:0] = evstat_q;
            irq_pkg::OFS_EVCLEAR:  rdata_d = 32'h0000_0000;
            irq_pkg::OFS_EVENABLE: rdata_d[irq_pkg::EV_W-1:0] = evenable_q;
            default:               addr_ok = 1'b0;
        endcase
    end

    // Every access waits exactly one cycle; data is captured while waitrequest is high
    assign rd_first = avs_read & wait_q;
    assign acc      = (avs_read | avs_write) & ~wait_q;
    assign wr_acc   = avs_write & ~wait_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~((avs_read | avs_write) & wait_q);
        end
    end

    // Read data held until the next read, so it stands at the accepting edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_first) begin
            rdata_q <= rdata_d;
        end
    end

    // Ports straight from flops
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign core_irq_req    = req_q;
    assign core_vector     = vec_q;
    assign core_gie        = gie_q;
    assign timer_a_level   = ta_pin_q;
    assign timer_ctrl      = tctrl_q[irq_pkg::TC_TIMER_LSB +: irq_pkg::TC_TIMER_W];
    assign irq             = irq_q;

endmodule

`default_nettype wire

/* File: tb/irq_prio_checker.sv */
// Purpose: Port-level assertions for the interrupt prioritizer.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Attached to every instance of the top module by bind.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_checker (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        nmi_pin,
    input wire logic        timer_a_input_pin,
    input wire logic        core_irq_ack,
    input wire logic        core_irq_req,
    input wire logic [15:0] core_vector,
    input wire logic        core_gie,
    input wire logic        timer_a_level
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Vectors stay word aligned inside the lowest sixteen words
    chk_vec_table: assert property (
        core_irq_req |-> core_vector[15:5] == 11'h000 && !core_vector[0])
        else $error("vector outside the table");
    // Reset slot is presented first after every release of reset
    chk_reset_first: assert property ($rose(rst_n) |=> core_irq_req && core_vector == 16'h0000)
        else $error("reset vector not first");
    // Non-maskable edge is offered within a few cycles whatever the enables
    chk_nmi_taken: assert property (
        $rose(nmi_pin) |-> ##[1:4] (core_irq_req && core_vector <= 16'h0002))
        else $error("non-maskable request not offered");
    // A maskable vector needs the global enable seen one cycle earlier
    chk_gated_by_gie: assert property (
        core_irq_req && core_vector > 16'h0002 |-> $past(core_gie))
        else $error("maskable request while disabled");
    // Acknowledge closes the global enable
    chk_ack_clears_gie: assert property (core_irq_ack && core_irq_req |=> !core_gie)
        else $error("enable kept after ack");
    // Acknowledge retires the shown request
    chk_ack_drops_req: assert property (core_irq_ack && core_irq_req |=> !core_irq_req)
        else $error("request kept after ack");
    // Timer A pin stays usable as a plain input while it also interrupts
    chk_timer_echo: assert property (timer_a_level == $past(timer_a_input_pin))
        else $error("timer A level not echoed");
    // Register access takes exactly one wait cycle
    chk_bus_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait");
    // Idle bus keeps waitrequest high
    chk_bus_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low while idle");
endmodule

bind vectored_interrupt_prioritizer irq_prio_checker u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .nmi_pin(nmi_pin),
    .timer_a_input_pin(timer_a_input_pin), .core_irq_ack(core_irq_ack),
    .core_irq_req(core_irq_req), .core_vector(core_vector), .core_gie(core_gie),
    .timer_a_level(timer_a_level)
);
`default_nettype wire

/* File: tb/core_partner.sv */
// Purpose: Behavioural processor core that takes vectored requests.
// Assumes: Request is a level; acknowledge is a one-cycle pulse.
// Notes:   The bench sets the wait before ack to model slow cores.
`timescale 1ns/1ps
`default_nettype none
module core_partner (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       core_irq_req,
    input  wire logic [3:0] dly,
    input  wire logic       reenable,
    output var logic        core_irq_ack,
    output var logic        enable_interrupts_instr
);
    // Ack only while a request stands, then reopen the enable as a return would
    initial begin
        core_irq_ack = 1'b0;
        enable_interrupts_instr = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (rst_n && core_irq_req === 1'b1) begin
                repeat (dly) @(posedge clk_sys);
                core_irq_ack <= 1'b1;
                @(posedge clk_sys);
                core_irq_ack <= 1'b0;
                @(posedge clk_sys);
                enable_interrupts_instr <= reenable;
                @(posedge clk_sys);
                enable_interrupts_instr <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/vectored_interrupt_prioritizer_tb_top.sv */
// Purpose: Self-checking bench for the interrupt prioritizer.
// Assumes: Core partner acks requests; a monitor checks vectors and reads.
// Notes:   Driver queues expected results; monitor pops them on each result.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_prioritizer_tb_top;
    logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic        core_irq_req, core_irq_ack, core_gie, en_pulse, dis_pulse, timer_a_level;
    logic        rx_is_addr, reenable;
    logic [7:0]  avs_address, rx_data, timer_ctrl;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] core_vector, src, m, en;
    logic [3:0]  dly;
    logic [31:0] rq[$];
    logic [15:0] vq[$];
    int          err_total, n_tests, cyc, seed, i, k;

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Source bits follow vector table order; bits 0 and 2 have no pin
    vectored_interrupt_prioritizer uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nmi_pin(src[1]), .ext_irq_two(src[3]),
        .low_strobe_irq(src[4]), .timer_a_output_irq(src[5]), .timer_a_input_pin(src[6]),
        .high_strobe_irq(src[7]), .rx_special_condition_irq(src[8]), .rx_word_valid(src[9]),
        .ext_irq_one(src[10]), .timer_b_output_irq(src[11]), .timer_b_input_irq(src[12]),
        .ext_irq_zero(src[13]), .transmit_irq(src[14]), .timer_c_irq(src[15]),
        .rx_word_is_addr(rx_is_addr), .rx_word_data(rx_data),
        .enable_interrupts_instr(en_pulse), .disable_interrupts_instr(dis_pulse),
        .core_irq_ack(core_irq_ack), .core_irq_req(core_irq_req),
        .core_vector(core_vector), .core_gie(core_gie), .timer_a_level(timer_a_level),
        .timer_ctrl(timer_ctrl), .irq(irq)
    );

    core_partner u_core (
        .clk_sys(clk_sys), .rst_n(rst_n), .core_irq_req(core_irq_req), .dly(dly),
        .reenable(reenable), .core_irq_ack(core_irq_ack), .enable_interrupts_instr(en_pulse)
    );

    task automatic conclude;
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic miss(input string s);
        err_total++;
        $display("MISMATCH %0t %s", $time, s);
    endtask

    task automatic cmp_vec(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) miss("vector");
    endtask

    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) miss("data word");
    endtask

    task automatic cmp_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) miss("interrupt level");
    endtask

    // Request held from one edge until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic fire(input logic [15:0] s);
        @(posedge clk_sys);
        src <= s;
        @(posedge clk_sys);
        src <= 16'h0000;
    endtask

    // Bounded wait until every expected vector has been taken
    task automatic drain;
        for (k = 0; k < 300 && vq.size() != 0; k++) @(posedge clk_sys);
        if (vq.size() != 0) miss("expected vector never taken");
        repeat (4) @(posedge clk_sys);
    endtask

    // Monitor: each result takes the oldest note; also cuts a hang short
    always @(posedge clk_sys) begin
        if (rst_n && core_irq_ack && core_irq_req === 1'b1) begin
            if (vq.size() == 0) miss("ack not expected");
            else cmp_vec(core_vector, vq.pop_front());
        end
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (rq.size() == 0) miss("read not expected");
            else cmp_word(avs_readdata, rq.pop_front());
        end
        cyc++;
        if (cyc > 6000) begin
            miss("timeout");
            conclude();
        end
    end

    initial begin
        seed = 32'h88a2;
        {rst_n, avs_read, avs_write, dis_pulse, rx_is_addr, reenable} = 6'h00;
        {avs_address, rx_data, avs_writedata, src, dly} = 68'h0;
        {err_total, n_tests, cyc} = 96'h0;
        vq.push_back(16'h0000);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        drain();
        rd(irq_pkg::OFS_LATCH, 32'h0000_0000);
        rd(irq_pkg::OFS_IENABLE, 32'h0000_0000);
        rd(irq_pkg::OFS_WAKE, 32'h0000_0000);
        wr(irq_pkg::OFS_TCTRL, 32'h0000_A50F);
        repeat (2) @(posedge clk_sys);
        cmp_word({24'h0, timer_ctrl}, 32'h0000_00A5);
        // Unmapped read sets the sticky status; then enable, mask, enable, clear
        rd(8'h40, 32'h0000_0000);
        for (i = 0; i < 4; i++) begin
            wr(i == 3 ? irq_pkg::OFS_EVCLEAR : irq_pkg::OFS_EVENABLE, i == 1 ? 32'h0 : 32'h8);
            repeat (3) @(posedge clk_sys);
            cmp_bit(irq, !i[0]);
        end
        rd(irq_pkg::OFS_EVCLEAR, 32'h0000_0000);
        // Random bursts: every pending enabled source is served in table order
        reenable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            m = 16'($random(seed));
            en = (i == 0) ? 16'hFFFF : 16'($random(seed));
            dly <= 4'(2 + {$random(seed)} % 4);
            wr(irq_pkg::OFS_IENABLE, {16'h0000, en});
            wr(irq_pkg::OFS_PSTATUS, 32'h0000_0001);
            for (k = 1; k < 16; k++)
                if (m[k] && k != 2 && (en[k] || k == 1)) vq.push_back(16'(2 * k));
            fire(m);
            drain();
            wr(irq_pkg::OFS_LATCH, 32'h0000_FFFF);
        end
        // Global enable closed: request is held but not offered until reopened
        reenable <= 1'b0;
        wr(irq_pkg::OFS_PSTATUS, 32'h0000_0001);
        @(posedge clk_sys);
        dis_pulse <= 1'b1;
        @(posedge clk_sys);
        dis_pulse <= 1'b0;
        rd(irq_pkg::OFS_PSTATUS, 32'h0000_0000);
        fire(16'h8000);
        repeat (6) @(posedge clk_sys);
        rd(irq_pkg::OFS_LATCH, 32'h0000_8000);
        // Last random mask may have left slot 15 disabled
        wr(irq_pkg::OFS_IENABLE, 32'h0000_8000);
        vq.push_back(16'h001E);
        wr(irq_pkg::OFS_PSTATUS, 32'h0000_0001);
        drain();
        rd(irq_pkg::OFS_PSTATUS, 32'h0000_0000);
        rd(irq_pkg::OFS_LASTVEC, 32'h0000_001E);
        // Wake filter: data word and foreign address are dropped
        wr(irq_pkg::OFS_WAKE, 32'h0000_5A03);
        for (i = 0; i < 3; i++) begin
            rx_is_addr <= (i != 0);
            rx_data <= (i == 1) ? 8'h33 : 8'h5A;
            fire(16'h0200);
            repeat (2) @(posedge clk_sys);
            rd(irq_pkg::OFS_LATCH, i == 2 ? 32'h0000_0200 : 32'h0000_0000);
        end
        // Second reset in mid-run brings the reset slot back first
        @(posedge clk_sys);
        rst_n <= 1'b0;
        vq.push_back(16'h0000);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        drain();
        conclude();
    end
endmodule
`default_nettype wire
